// File: rtl/mvrf_regfile.sv
// Masked wide vector register file with mask registers and prefix decode
// Functional notes
// - 32 wide registers in 64-bit mode
// - only 8 registers visible to operand reads and writeback in 32-bit mode
// - narrower views alias low register bits
// - eight 64-bit mask registers
// - mask slot zero means unconditional processing
// - merging or zeroing chosen by prefix bit
// - zeroing writes zero to masked-off elements
// - bits above written length are cleared
// - prefix names mask operand one to seven
// - masked memory access touches enabled elements
// - broadcast replicates fetched element everywhere
// - register fp ops take embedded rounding
// - prefix absorbs size, repeat and escapes
// - mask registers readable as element sources
// - prefix refused on legacy register classes
`timescale 1ns/100ps
`include "mvrf_defs.svh"
module mvrf_regfile #(
  parameter int NVREG = `MVRF_NUM_VREGS,
  parameter int NKREG = `MVRF_NUM_KREGS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Prefix decode
  input wire mvrf_pkg::mvrf_pfx_s pfx_i,
  output mvrf_pkg::mvrf_dec_s dec_o,
  // Operand reads
  input wire logic [4:0] rd_idx_a,
  input wire logic [4:0] rd_idx_b,
  input wire logic [2:0] rd_ksel,
  output logic [511:0] opnd_a_o,
  output logic [511:0] opnd_b_o,
  output logic [63:0] kpred_o,
  output logic [63:0] kvec_o,
  // Result writeback
  input wire mvrf_pkg::mvrf_wr_s wr_i,
  // Mask register write
  input wire logic kwr_vld,
  input wire logic [2:0] kwr_idx,
  input wire logic [63:0] kwr_data,
  // Memory operand
  input wire mvrf_pkg::mvrf_mem_s mem_i,
  output logic [63:0] mem_be_o,
  output logic [511:0] mem_opnd_o
);
  import mvrf_pkg::*;

  // Register storage
  logic [511:0] vreg_r [NVREG]; // Wide registers, views alias low bits
  logic [63:0] kreg_r [NKREG]; // Mask registers
  logic [31:0] ctrl_r; // Control word
  logic [8:0] rsel_r; // Debug read select {reg, word}
  logic [15:0] wcnt_r; // Writeback count
  logic ill_r; // Last decode refused

  // Effective register index for the operating mode
  function automatic logic [4:0] eff_idx(input logic m64, input logic [4:0] idx);
    eff_idx = m64 ? idx : {2'h0, idx[2:0]};
  endfunction : eff_idx

  // Replicate element zero across all byte positions
  function automatic logic [511:0] bcast_f(input logic [511:0] d, input logic [1:0] es);
    logic [5:0] lm;
    lm = 6'((8'h1 << es) - 8'h1);
    for (int i = 0; i < 64; i++)
    begin
      bcast_f[8*i +: 8] = d[8*(i & int'(lm)) +: 8];
    end
  endfunction : bcast_f

  // Mode and bus decode
  wire m64 = ctrl_r[`MVRF_CTRL_M64_BIT];
  wire apb_acc = psel & penable;
  wire hit_ctrl = (paddr == `MVRF_OFF_CTRL);
  wire hit_stat = (paddr == `MVRF_OFF_STAT);
  wire hit_rsel = (paddr == `MVRF_OFF_RSEL);
  wire hit_rdat = (paddr == `MVRF_OFF_RDATA);
  wire hit_any = hit_ctrl | hit_stat | hit_rsel | hit_rdat;
  wire [4:0] ri_dbg = rsel_r[8:4];
  wire [3:0] rw_dbg = rsel_r[3:0];
  wire [31:0] dbg_word = vreg_r[ri_dbg][32*rw_dbg +: 32];
  wire [31:0] stat_word = {wcnt_r, 14'h0, ill_r, m64};

  // Read mux, if chain on address
  logic [31:0] rd_mux;
  always_comb
  begin
    if (hit_ctrl)
      rd_mux = ctrl_r;
    else if (hit_stat)
      rd_mux = stat_word;
    else if (hit_rsel)
      rd_mux = {23'h0, rsel_r};
    else if (hit_rdat)
      rd_mux = dbg_word;
    else
      rd_mux = 32'h0;
  end

  // Zero-wait slave; unmapped access errors
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata = (apb_acc & ~pwrite) ? rd_mux : 32'h0;

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `MVRF_CTRL_RST;
      rsel_r <= 9'h0;
    end
    else if (apb_acc & pwrite)
    begin
      if (hit_ctrl)
        ctrl_r <= {31'h0, pwdata[`MVRF_CTRL_M64_BIT]};
      if (hit_rsel)
        rsel_r <= pwdata[8:0];
    end
  end

  // Prefix decode: map must be nonzero and class must be vector
  wire pfx_ok = pfx_i.vld & ~pfx_i.legacy & (pfx_i.mm != 2'h0);
  wire pfx_rc = pfx_i.b & pfx_i.fp_reg;
  mvrf_dec_s dec_nxt;
  always_comb
  begin
    dec_nxt.ok = pfx_ok;
    dec_nxt.illegal = pfx_i.vld & ~pfx_ok;
    dec_nxt.vl = pfx_rc ? MVRF_VL512 : pfx_i.ll;
    dec_nxt.z = pfx_i.z;
    dec_nxt.ksel = pfx_i.aaa;
    dec_nxt.bcast = pfx_i.b & ~pfx_i.fp_reg;
    dec_nxt.rc_en = pfx_rc;
    dec_nxt.rc = pfx_rc ? pfx_i.ll : 2'h0;
    dec_nxt.opx = pfx_i.pp;
    dec_nxt.map = pfx_i.mm;
    if (!pfx_ok)
    begin
      dec_nxt = '0;
      dec_nxt.illegal = pfx_i.vld;
    end
  end

  // Decode output register and refused flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_o <= '0;
      ill_r <= 1'b0;
    end
    else
    begin
      dec_o <= dec_nxt;
      if (pfx_i.vld)
        ill_r <= ~pfx_ok;
    end
  end

  // Writeback lanes
  logic [63:0] wb_act;
  logic [63:0] wb_inr;
  mvrf_lane_mask #(.BYTES(64)) u_wb_lane (
    .kval(kreg_r[wr_i.ksel]),
    .ksel(wr_i.ksel),
    .esize(wr_i.esize),
    .vl(wr_i.vl),
    .act_o(wb_act),
    .inr_o(wb_inr)
  );

  // Merged destination value
  wire [4:0] wdst = eff_idx(m64, wr_i.dst);
  wire [511:0] wold = vreg_r[wdst];
  wire wzero = wr_i.z & (wr_i.ksel != `MVRF_KSEL_NONE);
  logic [511:0] wb_nxt;
  genvar g;
  generate
    for (g = 0; g < 64; g++)
    begin : g_wb
      // Active takes result; inactive in range merges or zeroes; above length clears
      assign wb_nxt[8*g +: 8] = wb_act[g] ? wr_i.data[8*g +: 8] :
        (wb_inr[g] & ~wzero) ? wold[8*g +: 8] : 8'h0;
    end
  endgenerate

  // Vector registers, one write port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NVREG; i++)
        vreg_r[i] <= 512'h0;
      wcnt_r <= 16'h0;
    end
    else if (wr_i.vld)
    begin
      vreg_r[wdst] <= wb_nxt;
      wcnt_r <= wcnt_r + 16'h1;
    end
  end

  // Mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NKREG; i++)
        kreg_r[i] <= 64'h0;
    end
    else if (kwr_vld)
      kreg_r[kwr_idx] <= kwr_data;
  end

  // Operand and mask reads
  wire [63:0] kpred_nxt = (rd_ksel == `MVRF_KSEL_NONE) ? {64{1'b1}} : kreg_r[rd_ksel];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opnd_a_o <= 512'h0;
      opnd_b_o <= 512'h0;
      kpred_o <= 64'h0;
      kvec_o <= 64'h0;
    end
    else
    begin
      opnd_a_o <= vreg_r[eff_idx(m64, rd_idx_a)];
      opnd_b_o <= vreg_r[eff_idx(m64, rd_idx_b)];
      kpred_o <= kpred_nxt;
      kvec_o <= kreg_r[rd_ksel];
    end
  end

  // Memory operand lanes
  logic [63:0] mm_act;
  mvrf_lane_mask #(.BYTES(64)) u_mem_lane (
    .kval(kreg_r[mem_i.ksel]),
    .ksel(mem_i.ksel),
    .esize(mem_i.esize),
    .vl(mem_i.vl),
    .act_o(mm_act),
    .inr_o()
  );

  // Broadcast before masking; disabled bytes read as zero
  wire [511:0] mem_src = mem_i.bcast ? bcast_f(mem_i.data, mem_i.esize) : mem_i.data;
  logic [511:0] mem_gated;
  generate
    for (g = 0; g < 64; g++)
    begin : g_mem
      assign mem_gated[8*g +: 8] = mm_act[g] ? mem_src[8*g +: 8] : 8'h0;
    end
  endgenerate

  // Memory enables and operand
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_be_o <= 64'h0;
      mem_opnd_o <= 512'h0;
    end
    else
    begin
      mem_be_o <= mem_i.vld ? mm_act : 64'h0;
      mem_opnd_o <= mem_gated;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_masked_off;
    wr_i.vld && wr_i.ksel != 3'h0 && kreg_r[wr_i.ksel] == 64'h0 && wr_i.vl == 2'h0;
  endsequence

  AST_UPPER_CLEAR: assert property (
    (wr_i.vld && wr_i.vl == 2'h0) |=> vreg_r[$past(wdst)][511:128] == 384'h0)
    else $error("upper bits not cleared after short write");
  AST_ZEROING: assert property (
    (s_wr_masked_off and wr_i.z) |=> vreg_r[$past(wdst)][127:0] == 128'h0)
    else $error("zeroing left masked element nonzero");
  AST_MERGING: assert property (
    (s_wr_masked_off and !wr_i.z) |=> vreg_r[$past(wdst)][127:0] == $past(wold[127:0]))
    else $error("merging changed masked element");
  AST_UNCOND: assert property (
    (wr_i.vld && wr_i.ksel == 3'h0 && wr_i.vl == 2'h2) |=> vreg_r[$past(wdst)] == $past(wr_i.data))
    else $error("unconditional write not complete");
  AST_MODE32: assert property (
    !m64 |=> opnd_a_o == vreg_r[{2'h0, $past(rd_idx_a[2:0])}] || $past(wr_i.vld))
    else $error("register outside 32-bit window read");
  AST_BCAST: assert property (
    (mem_i.vld && mem_i.bcast && mem_i.esize == 2'h2 && mem_i.ksel == 3'h0
      && mem_i.vl == 2'h2) |=> mem_opnd_o[511:480] == mem_opnd_o[31:0])
    else $error("broadcast not replicated");
  AST_MEM_MASK: assert property (
    (mem_i.vld && mem_i.ksel != 3'h0 && kreg_r[mem_i.ksel] == 64'h0) |=> mem_be_o == 64'h0)
    else $error("masked memory element enabled");
  AST_LEGACY: assert property (
    (pfx_i.vld && pfx_i.legacy) |=> (dec_o.illegal && !dec_o.ok) ##1 (ill_r || $past(pfx_i.vld)))
    else $error("prefix accepted on legacy class");
  AST_ROUND: assert property (
    (pfx_ok && pfx_rc) |=> dec_o.rc_en && dec_o.rc == $past(pfx_i.ll) && dec_o.vl == 2'h2)
    else $error("embedded rounding not decoded");
  AST_KZERO_PRED: assert property (
    rd_ksel == 3'h0 |=> kpred_o == {64{1'b1}})
    else $error("slot zero not all ones");
  AST_KVEC: assert property (
    (kwr_vld && rd_ksel == kwr_idx) ##1 (rd_ksel == $past(kwr_idx)) |=> kvec_o == $past(kwr_data, 2))
    else $error("mask source read mismatch");
  // Accepted prefix carries its masking, mask, map and extension fields across
  AST_DEC_FIELDS: assert property (
    pfx_ok |=> dec_o.ok && dec_o.z == $past(pfx_i.z) && dec_o.ksel == $past(pfx_i.aaa)
      && dec_o.opx == $past(pfx_i.pp) && dec_o.map == $past(pfx_i.mm))
    else $error("accepted prefix fields not passed on");
  // Mid-width unconditional write fills the low view and clears above it
  AST_VIEW256: assert property (
    (wr_i.vld && wr_i.ksel == 3'h0 && wr_i.vl == 2'h1) |=>
      vreg_r[$past(wdst)] == {256'h0, $past(wr_i.data[255:0])})
    else $error("mid-width view not aliased to low bits");
  // Mask write lands in the addressed mask register
  AST_KWRITE: assert property (
    kwr_vld |=> kreg_r[$past(kwr_idx)] == $past(kwr_data))
    else $error("mask register write lost");
  // Wide mode reaches every register index unfolded
  AST_MODE64: assert property (
    m64 |=> opnd_a_o == vreg_r[$past(rd_idx_a)] || $past(wr_i.vld))
    else $error("register index folded in 64-bit mode");
endmodule : mvrf_regfile

// File: rtl/mvrf_defs.svh
// Register offsets, field positions, reset values and sizes of the vector register file
`ifndef MVRF_DEFS_SVH
`define MVRF_DEFS_SVH
`define MVRF_NUM_VREGS 32
`define MVRF_NUM_VREGS_M32 8
`define MVRF_VREG_BITS 512
`define MVRF_NUM_KREGS 8
`define MVRF_KREG_BITS 64
`define MVRF_OFF_CTRL 8'h00
`define MVRF_OFF_STAT 8'h04
`define MVRF_OFF_RSEL 8'h08
`define MVRF_OFF_RDATA 8'h0c
`define MVRF_CTRL_M64_BIT 0
`define MVRF_CTRL_RST 32'h0000_0001
`define MVRF_STAT_ILL_BIT 1
`define MVRF_STAT_CNT_LSB 16
`define MVRF_KSEL_NONE 3'h0
`endif

// File: rtl/mvrf_pkg.sv
// Types shared by the vector register file modules
package mvrf_pkg;
  // Vector length selector
  typedef enum logic [1:0] {MVRF_VL128 = 2'h0, MVRF_VL256 = 2'h1, MVRF_VL512 = 2'h2} mvrf_vl_e;
  // Prefix fields presented by the instruction decoder
  typedef struct packed {
    logic vld;
    logic legacy;
    logic [1:0] pp;
    logic [1:0] mm;
    logic [1:0] ll;
    logic z;
    logic [2:0] aaa;
    logic b;
    logic fp_reg;
  } mvrf_pfx_s;
  // Decoded prefix result
  typedef struct packed {
    logic ok;
    logic illegal;
    logic [1:0] vl;
    logic z;
    logic [2:0] ksel;
    logic bcast;
    logic rc_en;
    logic [1:0] rc;
    logic [1:0] opx;
    logic [1:0] map;
  } mvrf_dec_s;
  // Result writeback request
  typedef struct packed {
    logic vld;
    logic [4:0] dst;
    logic [2:0] ksel;
    logic z;
    logic [1:0] vl;
    logic [1:0] esize;
    logic [511:0] data;
  } mvrf_wr_s;
  // Memory vector operand request
  typedef struct packed {
    logic vld;
    logic [2:0] ksel;
    logic [1:0] vl;
    logic [1:0] esize;
    logic bcast;
    logic [511:0] data;
  } mvrf_mem_s;
endpackage : mvrf_pkg

// File: rtl/mvrf_lane_mask.sv
// Per-byte activity of a masked vector operation
`timescale 1ns/100ps
module mvrf_lane_mask #(
  parameter int BYTES = 64
) (
  // Mask source and selection
  input wire logic [63:0] kval,
  input wire logic [2:0] ksel,
  // Operation shape
  input wire logic [1:0] esize,
  input wire logic [1:0] vl,
  // Byte activity
  output logic [BYTES-1:0] act_o,
  output logic [BYTES-1:0] inr_o
);
  // Byte count covered by the vector length
  wire [7:0] span = 8'(8'h10 << vl);
  // Mask slot zero selects unconditional processing
  wire uncond = (ksel == 3'h0);

  // One lane per byte; element index is byte index over element size
  genvar b;
  generate
    for (b = 0; b < BYTES; b++)
    begin : g_lane
      wire [5:0] elem = 6'(b >> esize);
      assign inr_o[b] = (8'(b) < span);
      assign act_o[b] = inr_o[b] & (uncond | kval[elem]);
    end
  endgenerate
endmodule : mvrf_lane_mask

// File: tb/mvrf_exec_model.sv
// Execution datapath model that hands results to the register file
`timescale 1ns/100ps
module mvrf_exec_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Result request from the bench
  input wire mvrf_pkg::mvrf_wr_s req,
  // Writeback toward the register file
  output mvrf_pkg::mvrf_wr_s wr_o
);
  import mvrf_pkg::*;
  // One result stage, as a real pipe registers its output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_o <= '0;
    else
      wr_o <= req;
  end
endmodule : mvrf_exec_model

// File: tb/mvrf_regfile_tb.sv
// Self-checking bench for the masked vector register file
`timescale 1ns/100ps
module mvrf_regfile_tb;
  import mvrf_pkg::*;
  // Clock, reset and bus
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  // Datapath signals
  mvrf_pfx_s pfx_i;
  mvrf_dec_s dec_o;
  mvrf_wr_s req, wr_i;
  mvrf_mem_s mem_i;
  logic [4:0] rd_idx_a, rd_idx_b;
  logic [2:0] rd_ksel, kwr_idx, s;
  logic [1:0] l, e;
  logic kwr_vld, z, b;
  logic [63:0] kwr_data, kpred_o, kvec_o, mem_be_o, kx, bx;
  logic [511:0] opnd_a_o, opnd_b_o, mem_opnd_o, dv, ex;
  // Reference state
  logic [511:0] vr [32];
  logic [63:0] km [8];
  logic [31:0] seed = 32'h7cd5;
  int miscompares = 0;
  int n_checks = 0;
  // Design and partner
  mvrf_regfile DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pfx_i, .dec_o, .rd_idx_a, .rd_idx_b,
    .rd_ksel, .opnd_a_o, .opnd_b_o, .kpred_o, .kvec_o, .wr_i, .kwr_vld,
    .kwr_idx, .kwr_data, .mem_i, .mem_be_o, .mem_opnd_o);
  mvrf_exec_model PRT (.pclk, .presetn, .req, .wr_o(wr_i));
  // Clock
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [511:0] r512();
    logic [511:0] v;
    for (int i = 0; i < 16; i++) v[i*32+:32] = xs();
    return v;
  endfunction : r512
  // Expected register after a masked write
  function automatic logic [511:0] wexp(logic [511:0] o, n, logic [63:0] k,
    logic [2:0] ks, logic zz, logic [1:0] vl, es);
    logic [511:0] v;
    for (int i = 0; i < 64; i++)
      v[i*8+:8] = (i >= (16 << vl)) ? 8'h0 : (ks == 0 || k[i>>es]) ? n[i*8+:8] :
        zz ? 8'h0 : o[i*8+:8];
    return v;
  endfunction : wexp
  // Expected memory enables and operand
  function automatic void mexp(logic [511:0] d, logic [63:0] k, logic [2:0] ks,
    logic [1:0] vl, es, logic bc, output logic [63:0] be, output logic [511:0] v);
    for (int i = 0; i < 64; i++)
    begin
      be[i] = (i < (16 << vl)) && (ks == 0 || k[i>>es]);
      v[i*8+:8] = !be[i] ? 8'h0 : bc ? d[(i%(1<<es))*8+:8] : d[i*8+:8];
    end
  endfunction : mexp
  // Compare and count
  task chk(string n, logic [511:0] x, logic [511:0] g);
    n_checks++;
    if (g !== x)
    begin
      $display("Error %s exp %h got %h", n, x, g);
      miscompares++;
    end
  endtask : chk
  // One bus transfer, held until ready
  task apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
    output logic er);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Wait ends once pready is high; the watchdog ends it otherwise
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Result write through the partner, then read back
  task wr(logic [4:0] d);
    dv = r512();
    ex = wexp(vr[d], dv, km[s], s, z, l, e);
    vr[d] = ex;
    @(posedge pclk);
    req <= '{1'b1, d, s, z, l, e, dv};
    @(posedge pclk);
    req.vld <= 1'b0;
    @(posedge pclk);
    rd_idx_a <= d;
    rd_idx_b <= d ^ 5'h1;
    @(posedge pclk);
    #1;
    chk("vreg", ex, opnd_a_o);
    chk("opnd_b", vr[d ^ 5'h1], opnd_b_o);
  endtask : wr
  // Prefix presented, decode sampled
  task pf(mvrf_pfx_s p);
    @(posedge pclk);
    pfx_i <= p;
    @(posedge pclk);
    #1;
  endtask : pf
  // Verdict
  task report_and_stop();
    $display("checks %0d errors %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, kwr_vld, kwr_idx} = '0;
    {pfx_i, req, mem_i, rd_idx_a, rd_idx_b, rd_ksel, kwr_data} = '0;
    foreach (vr[i]) vr[i] = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h00, 0, rv, ev);
    chk("ctrl", 1, rv);
    apb(0, 8'h10, 0, rv, ev);
    chk("slverr", 1, ev);
    // Back-to-back mask writes
    for (int k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      km[k] = (k == 7) ? 64'h0 : {xs(), xs()}; // Slot 7 stays empty for corners
      kwr_vld <= 1;
      kwr_idx <= k[2:0];
      kwr_data <= km[k];
    end
    @(posedge pclk);
    kwr_vld <= 0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      rd_ksel <= k[2:0];
      @(posedge pclk);
      #1;
      chk("kvec", km[k], kvec_o);
      chk("kpred", k == 0 ? {64{1'b1}} : km[k], kpred_o);
    end
    // Fill all registers, random masked writes, then empty-mask and mid-width corners
    for (int i = 0; i < 64; i++)
    begin
      kx = {32'h0, xs()};
      if (i < 32)
        {l, s, z, e} = {2'h2, 3'h0, 1'b0, 2'h0};
      else if (i < 60)
        {l, s, z, e} = {kx[9:8] % 2'd3, kx[2:0], kx[3], kx[13:12]};
      else
        {l, s, z, e} = {i[1] ? 2'h1 : 2'h0, i[1] ? 3'h0 : 3'h7, ~i[0], i[1:0]};
      wr((i < 32) ? i[4:0] : kx[20:16]);
    end
    apb(1, 8'h08, 32'h50, rv, ev);
    apb(0, 8'h0c, 0, rv, ev);
    chk("rdata", vr[5][31:0], rv);
    // Prefix decode cases
    pf('{1, 0, 2'h2, 2'h1, 2'h1, 1, 3'h3, 0, 0});
    chk("dec", {1'b1, 1'b0, 2'h1, 1'b1, 3'h3, 2'h2, 2'h1},
      {dec_o.ok, dec_o.illegal, dec_o.vl, dec_o.z, dec_o.ksel, dec_o.opx, dec_o.map});
    pf('{1, 1, 2'h0, 2'h1, 2'h0, 0, 3'h0, 0, 0});
    chk("legacy", 2'b01, {dec_o.ok, dec_o.illegal});
    pf('{1, 0, 2'h0, 2'h0, 2'h0, 0, 3'h0, 0, 0});
    chk("map0", 2'b01, {dec_o.ok, dec_o.illegal});
    // Status: 64 writes so far, refused prefix still presented, wide mode
    apb(0, 8'h04, 0, rv, ev);
    chk("stat", {16'd64, 14'h0, 1'b1, 1'b1}, rv);
    pf('{1, 0, 2'h0, 2'h2, 2'h3, 0, 3'h1, 1, 1});
    chk("round", {1'b1, 2'h3, 2'h2}, {dec_o.rc_en, dec_o.rc, dec_o.vl});
    pf('{1, 0, 2'h0, 2'h3, 2'h2, 0, 3'h1, 1, 0});
    chk("bcast", 1, dec_o.bcast);
    // Masked and broadcast memory operands
    for (int i = 0; i < 12; i++)
    begin
      kx = {32'h0, xs()};
      dv = r512();
      // First two passes: an empty mask, then a full-width word broadcast
      if (i == 0)
        {s, l, e, b} = {3'h7, 2'h2, 2'h0, 1'b0};
      else if (i == 1)
        {s, l, e, b} = {3'h0, 2'h2, 2'h2, 1'b1};
      else
        {s, l, e, b} = {kx[2:0], kx[4:3] % 2'd3, kx[6:5], kx[7]};
      mexp(dv, km[s], s, l, e, b, bx, ex);
      @(posedge pclk);
      mem_i <= '{1'b1, s, l, e, b, dv};
      @(posedge pclk);
      mem_i.vld <= 0;
      #1;
      chk("mem_be", bx, mem_be_o);
      chk("mem_op", ex, mem_opnd_o);
    end
    // Narrow mode folds register indices
    apb(1, 8'h00, 0, rv, ev);
    @(posedge pclk);
    rd_idx_a <= 5'd13;
    @(posedge pclk);
    #1;
    chk("mode32", vr[5], opnd_a_o);
    report_and_stop();
  end
endmodule : mvrf_regfile_tb
